// ---- core/swlm_pkg.sv ----
package swlm_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  // outbound reset pulse after a watchdog expiry or power-on
  localparam int unsigned RST_HOLD_NS   = 1000;
  localparam int unsigned RST_HOLD_CYC  =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // watchdog time base
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYC        = MS_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  WD_DEFAULT_MS = 8'h40;

  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [3:0]  SPI_BITS      = 4'h8;
  localparam logic [3:0]  SPI_CNT_SAT   = 4'h9;

  localparam logic [1:0]  MODE_SLEEP    = 2'h0;
  localparam logic [1:0]  MODE_STOP     = 2'h1;
  localparam logic [1:0]  MODE_WD_CLEAR = 2'h2;
  localparam logic [1:0]  MODE_RUN      = 2'h3;

  localparam logic [1:0]  SLEW_20K      = 2'h0;
  localparam logic [1:0]  SLEW_10K      = 2'h1;
  localparam logic [1:0]  SLEW_100K     = 2'h2;
  localparam logic [1:0]  SLEW_LP_REQ   = 2'h3;

  // control byte, D7 down to D0
  typedef struct packed {
    logic [1:0] lin_slew_select;
    logic       bus_pullup_release;
    logic       switch3_enable;
    logic       switch2_enable;
    logic       switch1_enable;
    logic [1:0] operating_state_select;
  } swlm_ctrl_t;

  // raw condition lines from the analog sensors
  typedef struct packed {
    logic [2:0] switch_overtemp;
    logic       overvoltage;
    logic       undervoltage;
    logic       battery_loss;
    logic       regulator_thermal;
    logic       bus_fault;
    logic       bus_wake;
  } swlm_analog_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_SLEEP = 3'b010,
    ST_STOP  = 3'b100
  } swlm_op_t;

endpackage : swlm_pkg

// ---- core/swlm_spi_byte.sv ----
`timescale 1ns/100ps
module swlm_spi_byte (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       cs_n,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte,
  output logic            rx_valid
);
  import swlm_pkg::*;

  typedef struct packed {
    logic [1:0] sck_s;
    logic [1:0] mosi_s;
    logic [1:0] cs_s;
    logic       sck_d;
    logic       cs_d;
    logic [3:0] cnt;
    logic [7:0] sh_in;
    logic [7:0] sh_out;
    logic [7:0] rx;
    logic       vld;
  } swlm_spi_state_t;

  swlm_spi_state_t s_reg;
  swlm_spi_state_t s_next;

  logic sel;
  logic sck_rise;
  logic sck_fall;

  assign sel      = ~s_reg.cs_s[1];
  assign sck_rise = s_reg.sck_s[1] & ~s_reg.sck_d;
  assign sck_fall = ~s_reg.sck_s[1] & s_reg.sck_d;

  always_comb begin
    s_next        = s_reg;
    s_next.vld    = 1'b0;
    s_next.sck_s  = {s_reg.sck_s[0], sclk};
    s_next.mosi_s = {s_reg.mosi_s[0], mosi};
    s_next.cs_s   = {s_reg.cs_s[0], cs_n};
    s_next.sck_d  = s_reg.sck_s[1];
    s_next.cs_d   = s_reg.cs_s[1];
    // status byte is captured at select, shifted out msb first
    if (s_reg.cs_d & ~s_reg.cs_s[1]) begin
      s_next.sh_out = tx_byte;
      s_next.cnt    = 4'h0;
    end else if (sel & sck_rise) begin
      s_next.sh_in = {s_reg.sh_in[6:0], s_reg.mosi_s[1]};
      if (s_reg.cnt != SPI_CNT_SAT) begin
        s_next.cnt = s_reg.cnt + 4'h1;
      end
    end else if (sel & sck_fall) begin
      s_next.sh_out = {s_reg.sh_out[6:0], 1'b0};
    end
    // only a whole byte counts as a transfer
    if (~s_reg.cs_d & s_reg.cs_s[1] & (s_reg.cnt == SPI_BITS)) begin
      s_next.rx  = s_reg.sh_in;
      s_next.vld = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg      <= '0;
      // select is idle high, so no false deselect edge follows reset
      s_reg.cs_s <= 2'b11;
      s_reg.cs_d <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign miso     = s_reg.sh_out[7];
  assign rx_byte  = s_reg.rx;
  assign rx_valid = s_reg.vld;

endmodule : swlm_spi_byte

// ---- core/swlm_port.sv ----
`timescale 1ns/100ps
module swlm_port #(
  parameter int unsigned TICK_CYC      = swlm_pkg::MS_CYC,
  parameter logic [7:0]  WD_DEFAULT_MS = swlm_pkg::WD_DEFAULT_MS
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   spi_sclk,
  input  wire logic                   spi_mosi,
  input  wire logic                   spi_cs_n,
  output logic                        spi_miso,
  input  wire logic                   direct_pulse_input,
  input  wire logic                   wake_input_a,
  input  wire logic                   wake_input_b,
  input  wire swlm_pkg::swlm_analog_t analog_in,
  input  wire logic                   wd_pin_grounded,
  input  wire logic                   wd_pin_open,
  input  wire logic [7:0]             wd_period_ms,
  input  wire logic                   lin_rx_in,
  output logic                        lin_rxd_out,
  output logic                        switch_out_a,
  output logic                        switch_out_b,
  output logic                        switch_out_c,
  output logic [1:0]                  lin_slew_select,
  output logic                        pullup_connect,
  output logic                        pullup_current_en,
  output logic                        sleep_mode,
  output logic                        stop_mode,
  output logic                        irq_n,
  output logic                        rst_o,
  output logic                        rst_oe
);
  import swlm_pkg::*;

  typedef struct packed {
    logic [1:0]   pwm_s;
    logic [1:0]   wa_s;
    logic [1:0]   wb_s;
    logic [1:0]   lin_s;
    logic [1:0]   cfg_g_s;
    logic [1:0]   cfg_o_s;
    logic [7:0]   per_s0;
    logic [7:0]   per_s1;
    swlm_analog_t an_s0;
    swlm_analog_t an_s1;
    logic         wa_d;
    logic         wb_d;
    swlm_ctrl_t   ctrl;
    swlm_op_t     op;
    logic [1:0]   pend_mode;
    logic         pend_valid;
    logic         sw_th;
    logic         bus_wk;
    logic         bus_flt;
    logic         ov;
    logic         uv;
    logic         bf;
    logic         reg_th;
    logic         wake_ev;
    logic         first_rd;
    logic [16:0]  tick_cnt;
    logic [7:0]   wd_ms;
    logic [7:0]   rst_cnt;
    logic         rst_act;
    logic         sw_a;
    logic         sw_b;
    logic         sw_c;
    logic         rxd;
    logic         irq;
    logic         pu_rel;
  } swlm_state_t;

  swlm_state_t s;
  swlm_state_t n;

  logic [7:0] rx_byte;
  logic       rx_valid;
  logic [7:0] status_byte;
  swlm_ctrl_t rx_ctrl;
  logic       rd_done;
  logic       in_run;
  logic       any_flag;
  logic       wake_edge;
  logic       wd_run;
  logic       wd_clear;
  logic [7:0] wd_period;
  logic       wd_expire;
  logic       sw_off;

  function automatic logic is_lp_cmd(input logic [1:0] m);
    return (m == MODE_SLEEP) || (m == MODE_STOP);
  endfunction : is_lp_cmd

  swlm_spi_byte u_spi (
    .clk      (clk),
    .arst_n   (arst_n),
    .sclk     (spi_sclk),
    .mosi     (spi_mosi),
    .cs_n     (spi_cs_n),
    .tx_byte  (status_byte),
    .miso     (spi_miso),
    .rx_byte  (rx_byte),
    .rx_valid (rx_valid)
  );

  assign rx_ctrl   = swlm_ctrl_t'(rx_byte);
  assign rd_done   = rx_valid;
  assign in_run    = (s.op == ST_RUN);
  assign any_flag  = s.sw_th | s.bus_wk | s.bus_flt | s.ov | s.uv
                   | s.bf | s.reg_th | s.wake_ev;
  assign wake_edge = (s.wa_s[1] ^ s.wa_d) | (s.wb_s[1] ^ s.wb_d);

  // readback byte; wake levels only meaningful in run
  assign status_byte = {any_flag,
                        s.bus_wk | s.bus_flt,
                        s.ov,
                        s.first_rd ? s.bf : s.uv,
                        s.reg_th,
                        s.sw_th,
                        in_run & s.wb_s[1],
                        in_run & s.wa_s[1]};

  // watchdog runs only in run, outside reset, pin not grounded
  assign wd_run    = in_run & ~s.rst_act & ~s.cfg_g_s[1];
  assign wd_clear  = rd_done
                   & (rx_ctrl.operating_state_select == MODE_WD_CLEAR);
  assign wd_period = s.cfg_o_s[1] ? WD_DEFAULT_MS : s.per_s1;
  assign wd_expire = wd_run & ~wd_clear & (s.wd_ms >= wd_period);

  assign sw_off = s.sw_th | ~in_run;

  always_comb begin
    n         = s;
    n.pwm_s   = {s.pwm_s[0], direct_pulse_input};
    n.wa_s    = {s.wa_s[0], wake_input_a};
    n.wb_s    = {s.wb_s[0], wake_input_b};
    n.lin_s   = {s.lin_s[0], lin_rx_in};
    n.cfg_g_s = {s.cfg_g_s[0], wd_pin_grounded};
    n.cfg_o_s = {s.cfg_o_s[0], wd_pin_open};
    n.per_s0  = wd_period_ms;
    n.per_s1  = s.per_s0;
    n.an_s0   = analog_in;
    n.an_s1   = s.an_s0;
    n.wa_d    = s.wa_s[1];
    n.wb_d    = s.wb_s[1];

    // sticky flags cleared by a completed read; a new event wins
    n.sw_th   = (s.sw_th & ~rd_done) | (|s.an_s1.switch_overtemp);
    n.bus_wk  = (s.bus_wk & ~rd_done) | s.an_s1.bus_wake;
    n.bus_flt = (s.bus_flt & ~rd_done) | s.an_s1.bus_fault;
    n.ov      = (s.ov & ~rd_done) | s.an_s1.overvoltage;
    n.uv      = (s.uv & ~rd_done) | s.an_s1.undervoltage;
    n.bf      = (s.bf & ~rd_done) | s.an_s1.battery_loss;
    n.reg_th  = (s.reg_th & ~rd_done) | s.an_s1.regulator_thermal;
    n.wake_ev = (s.wake_ev & ~rd_done) | (wake_edge & ~in_run);
    if (rd_done) begin
      n.first_rd = 1'b0;
    end

    // every transfer also writes the control byte, unless a watchdog expiry falls in the same cycle
    if (rd_done) begin
      n.ctrl = rx_ctrl;
      if (is_lp_cmd(rx_ctrl.operating_state_select)) begin
        if (s.pend_valid && in_run &&
            (s.pend_mode == rx_ctrl.operating_state_select)) begin
          // second identical command: enter low power
          n.op = (rx_ctrl.operating_state_select == MODE_SLEEP)
               ? ST_SLEEP : ST_STOP;
          n.pend_valid = 1'b0;
        end else begin
          n.pend_valid = 1'b1;
          n.pend_mode  = rx_ctrl.operating_state_select;
        end
      end else begin
        n.pend_valid = 1'b0;
      end
    end

    unique case (s.op)
      ST_RUN: begin
      end
      ST_SLEEP, ST_STOP: begin
        if (wake_edge) begin
          n.op         = ST_RUN;
          n.pend_valid = 1'b0;
        end
      end
      default: begin
        n.op = ST_RUN;
      end
    endcase

    // watchdog time base in milliseconds
    if (!wd_run || wd_clear) begin
      n.tick_cnt = 17'h00000;
      n.wd_ms    = 8'h00;
    end else if (s.tick_cnt == 17'(TICK_CYC - 1)) begin
      n.tick_cnt = 17'h00000;
      if (s.wd_ms != 8'hFF) begin
        n.wd_ms = s.wd_ms + 8'h01;
      end
    end else begin
      n.tick_cnt = s.tick_cnt + 17'h00001;
    end

    if (s.rst_cnt != 8'h00) begin
      n.rst_cnt = s.rst_cnt - 8'h01;
    end

    // ordinary reset: control byte but the pull-up release bit, mode, watchdog; flags kept
    if (wd_expire) begin
      n.ctrl = swlm_ctrl_t'(CTRL_RESET);
      n.ctrl.bus_pullup_release = s.ctrl.bus_pullup_release;
      n.op         = ST_RUN;
      n.pend_valid = 1'b0;
      n.first_rd   = 1'b1;
      n.tick_cnt   = 17'h00000;
      n.wd_ms      = 8'h00;
      n.rst_cnt    = RST_HOLD_CYC[7:0];
    end
    n.rst_act = (s.rst_cnt != 8'h00);

    n.sw_a = s.ctrl.switch1_enable & s.pwm_s[1] & ~sw_off;
    n.sw_b = s.ctrl.switch2_enable & s.pwm_s[1] & ~sw_off;
    n.sw_c = s.ctrl.switch3_enable & ~sw_off;
    n.rxd    = s.lin_s[1];
    n.irq    = any_flag;
    n.pu_rel = ~in_run & s.ctrl.bus_pullup_release;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s          <= '0;
      s.op       <= ST_RUN;
      s.first_rd <= 1'b1;
      s.rst_cnt  <= RST_HOLD_CYC[7:0];
      s.rst_act  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign switch_out_a      = s.sw_a;
  assign switch_out_b      = s.sw_b;
  assign switch_out_c      = s.sw_c;
  assign lin_rxd_out       = s.rxd;
  assign lin_slew_select   = s.ctrl.lin_slew_select;
  assign pullup_connect    = ~s.pu_rel;
  assign pullup_current_en = s.pu_rel;
  assign sleep_mode        = (s.op == ST_SLEEP);
  assign stop_mode         = (s.op == ST_STOP);
  assign irq_n             = ~s.irq;
  assign rst_o             = 1'b0;
  assign rst_oe            = s.rst_act;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_sw_gating: assert property (
    switch_out_a |-> $past(s.ctrl.switch1_enable && s.pwm_s[1]
                           && !s.sw_th && s.op == ST_RUN))
    else $error("switch a on without enable and pulse");

  a_sw3_alone: assert property (
    $past(s.ctrl.switch3_enable && !s.sw_th && s.op == ST_RUN)
    |-> switch_out_c)
    else $error("switch c not following its enable");

  a_thermal_latch: assert property (
    (s.an_s1.switch_overtemp != 3'h0)
    |=> s.sw_th ##1 (!switch_out_a && !switch_out_b && !switch_out_c))
    else $error("overtemperature did not latch switches off");

  a_lowpower_off: assert property (
    (s.op != ST_RUN) |=> !(switch_out_a || switch_out_b || switch_out_c))
    else $error("switch on in low power");

  a_soft_reset: assert property (
    wd_expire |=> (lin_slew_select == SLEW_20K)
      && (s.ctrl.switch1_enable == 1'b0)
      && (s.ctrl.bus_pullup_release == $past(s.ctrl.bus_pullup_release)))
    else $error("ordinary reset left control bits wrong");

  a_pullup_swap: assert property (
    (s.op != ST_RUN && s.ctrl.bus_pullup_release)
    |=> pullup_current_en && !pullup_connect)
    else $error("pull-up not released in low power");

  a_double_cmd: assert property (
    $rose(sleep_mode) |-> $past(rd_done && s.pend_valid
                                && s.pend_mode == MODE_SLEEP))
    else $error("sleep entered without a repeated command");

  a_wake_exit: assert property (
    (s.op != ST_RUN && wake_edge) |=> (s.op == ST_RUN) && s.wake_ev)
    else $error("wake transition did not return to run");

  a_irq_flag: assert property (
    any_flag |=> !irq_n)
    else $error("flag set but interrupt output idle");

  a_rxd_follow: assert property (
    lin_rxd_out == $past(s.lin_s[1]))
    else $error("receive output not following bus");

  a_wd_reset: assert property (
    wd_expire |=> ##1 rst_oe [*8])
    else $error("watchdog expiry without reset pulse");

  c_sleep_entry: cover property ($rose(sleep_mode));
  c_stop_wake:   cover property (stop_mode ##1 !stop_mode);
  c_wd_expire:   cover property (wd_expire);
  c_thermal:     cover property ($rose(s.sw_th));

endmodule : swlm_port

// ---- verification/swlm_spi_master.sv ----
`timescale 1ns/100ps
module swlm_spi_master (
  input  wire logic clk,
  input  wire logic spi_miso,
  output logic      spi_sclk,
  output logic      spi_mosi,
  output logic      spi_cs_n
);
  initial begin
    spi_sclk = 1'b0;
    spi_mosi = 1'b1;
    spi_cs_n = 1'b1;
  end

  // one full-duplex frame, msb first; n other than 8 is a broken frame
  task automatic xfer(
    input  logic [7:0] tx,
    input  int         n,
    output logic [7:0] rx
  );
    rx = 8'h00;
    @(negedge clk);
    #1 spi_cs_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      spi_mosi = tx[7 - (k % 8)];
      #((k == 0) ? 64 : 32);
      rx = {rx[6:0], spi_miso};
      spi_sclk = 1'b1;
      #32 spi_sclk = 1'b0;
    end
    #32 spi_cs_n = 1'b1;
    // deselected data line must not look like the last bit
    spi_mosi = ~spi_mosi;
    #80;
  endtask : xfer
endmodule : swlm_spi_master

// ---- verification/swlm_port_test.sv ----
`timescale 1ns/100ps
module swlm_port_test;
  import swlm_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic       pwm;
    logic [2:0] sw;
  } swlm_row_t;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  logic         sclk, mosi, cs_n, miso, pwm, wa, wb, wd_gnd, wd_open;
  logic         rx_in, rxd, sw_a, sw_b, sw_c, pu_con, pu_cur, slp, stp;
  logic         irq_n, rst_o, rst_oe;
  logic [1:0]   slew;
  logic [7:0]   wd_ms, st;
  swlm_analog_t an;
  int           miscompares = 0;
  int           tests_run = 0;
  int           cyc = 0;
  swlm_row_t    rows [6] = '{'{8'h1F, 1'b1, 3'b111}, '{8'h1F, 1'b0, 3'b100},
    '{8'h4B, 1'b1, 3'b010}, '{8'h86, 1'b1, 3'b001},
    '{8'hD3, 1'b0, 3'b100}, '{8'h0F, 1'b0, 3'b000}};

  swlm_port #(.TICK_CYC(20)) u_swlm_port (
    .clk(clk), .arst_n(arst_n), .spi_sclk(sclk), .spi_mosi(mosi),
    .spi_cs_n(cs_n), .spi_miso(miso), .direct_pulse_input(pwm),
    .wake_input_a(wa), .wake_input_b(wb), .analog_in(an),
    .wd_pin_grounded(wd_gnd), .wd_pin_open(wd_open), .wd_period_ms(wd_ms),
    .lin_rx_in(rx_in), .lin_rxd_out(rxd), .switch_out_a(sw_a),
    .switch_out_b(sw_b), .switch_out_c(sw_c), .lin_slew_select(slew),
    .pullup_connect(pu_con), .pullup_current_en(pu_cur),
    .sleep_mode(slp), .stop_mode(stp), .irq_n(irq_n), .rst_o(rst_o),
    .rst_oe(rst_oe)
  );

  swlm_spi_master u_swlm_spi_master (
    .clk(clk), .spi_miso(miso), .spi_sclk(sclk), .spi_mosi(mosi),
    .spi_cs_n(cs_n)
  );

  always #4 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] tx, input int n = 8);
    u_swlm_spi_master.xfer(tx, n, st);
  endtask : xfer

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  function automatic logic [7:0] sw3();
    return {5'h00, sw_c, sw_b, sw_a};
  endfunction : sw3

  initial begin
    pwm = 1'b1;
    wa = 1'b0;
    wb = 1'b0;
    an = '0;
    an.battery_loss = 1'b1;
    wd_gnd = 1'b1;
    wd_open = 1'b0;
    wd_ms = 8'h02;
    rx_in = 1'b0;
    settle(2);
    chk("sw_rst", 8'h00, sw3());
    chk("slew_rst", 8'h00, {6'h00, slew});
    chk("pull_rst", 8'h01, {6'h00, pu_cur, pu_con});
    chk("rst_out", 8'h01, {6'h00, rst_o, rst_oe});
    arst_n = 1'b1;
    settle(140);
    chk("rst_end", 8'h00, {6'h00, rst_o, rst_oe});
    xfer(8'h03);
    chk("st_first", 8'h90, st & 8'h97);
    wa = 1'b1;
    settle(8);
    xfer(8'h03);
    chk("st_second", 8'h01, st & 8'h17);
    an.battery_loss = 1'b0;
    foreach (rows[i]) begin
      pwm = rows[i].pwm;
      xfer(rows[i].ctrl);
      chk("sw_row", {5'h00, rows[i].sw}, sw3());
      chk("slew_row", {6'h00, rows[i].ctrl[7:6]}, {6'h00, slew});
      chk("mode_row", 8'h00, {6'h00, stp, slp});
    end
    pwm = 1'b1;
    xfer(8'h1F);
    chk("irq_idle", 8'h01, {7'h00, irq_n});
    an.switch_overtemp = 3'b010;
    settle(8);
    chk("sw_hot", 8'h00, sw3());
    chk("irq_hot", 8'h00, {7'h00, irq_n});
    an.switch_overtemp = 3'b000;
    settle(8);
    chk("sw_latch", 8'h00, sw3());
    xfer(8'h1F);
    chk("st_hot", 8'h04, st & 8'h04);
    chk("sw_free", 8'h07, sw3());
    xfer(8'h03, 7);
    chk("sw_short", 8'h07, sw3());
    xfer(8'h3C);
    chk("sleep_one", 8'h00, {6'h00, stp, slp});
    chk("sw_one", 8'h07, sw3());
    xfer(8'h3C);
    chk("sleep_two", 8'h01, {6'h00, stp, slp});
    chk("sw_sleep", 8'h00, sw3());
    chk("pull_sleep", 8'h02, {6'h00, pu_cur, pu_con});
    chk("irq_sleep", 8'h01, {7'h00, irq_n});
    wa = 1'b0;
    settle(8);
    chk("wake_a", 8'h00, {6'h00, stp, slp});
    chk("irq_wake", 8'h00, {7'h00, irq_n});
    xfer(8'h01);
    xfer(8'h03);
    xfer(8'h01);
    chk("stop_cancel", 8'h00, {6'h00, stp, slp});
    xfer(8'h01);
    chk("stop_two", 8'h02, {6'h00, stp, slp});
    chk("pull_stop", 8'h01, {6'h00, pu_cur, pu_con});
    wb = 1'b1;
    settle(8);
    chk("wake_b", 8'h00, {6'h00, stp, slp});
    for (int i = 0; i < 2; i++) begin
      rx_in = ~rx_in;
      settle(6);
      chk("rxd", {7'h00, rx_in}, {7'h00, rxd});
    end
    an.overvoltage = 1'b1;
    an.undervoltage = 1'b1;
    an.regulator_thermal = 1'b1;
    an.bus_fault = 1'b1;
    settle(4);
    an = '0;
    settle(4);
    xfer(8'h03);
    chk("st_flags", 8'hF8, st & 8'hFC);
    xfer(8'h03);
    chk("st_clear", 8'h00, st & 8'hFC);
    xfer(8'hBF);
    chk("wd_off", 8'h00, {7'h00, rst_oe});
    wd_gnd = 1'b0;
    for (int i = 0; i < 300 && rst_oe !== 1'b1; i++) settle(1);
    chk("wd_fire", 8'h01, {7'h00, rst_oe});
    settle(3);
    chk("sw_wd", 8'h00, sw3());
    chk("slew_wd", 8'h00, {6'h00, slew});
    wd_open = 1'b1;
    for (int i = 0; i < 200 && rst_oe !== 1'b0; i++) settle(1);
    settle(int'(WD_DEFAULT_MS) * 20 - 40);
    chk("wd_dflt_early", 8'h00, {7'h00, rst_oe});
    for (int i = 0; i < 100 && rst_oe !== 1'b1; i++) settle(1);
    chk("wd_dflt_fire", 8'h01, {7'h00, rst_oe});
    xfer(8'hDF);
    chk("slew_pre", 8'h03, {6'h00, slew});
    arst_n = 1'b0;
    settle(2);
    chk("sw_mid", 8'h00, sw3());
    chk("slew_mid", 8'h00, {6'h00, slew});
    chk("rst_mid", 8'h01, {6'h00, rst_o, rst_oe});
    arst_n = 1'b1;
    settle(140);
    chk("rst_end_mid", 8'h00, {6'h00, rst_o, rst_oe});
    print_verdict();
  end
endmodule : swlm_port_test
